//--- bench/alsw_checker.sv
// Port checker for the input-2 loss and sleep/wake block.
// Assumes it is bound onto alsw_ctrl and sees only its ports.
module alsw_checker #(
  parameter TICK_CYCLES = 10
) (
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // Watched signals
  input wire [15:0] in2_raw_level,
  input wire drive_running,
  input wire loss_active,
  input wire input_loss_fault,
  input wire stop_req,
  input wire ref_override,
  input wire [15:0] ref_value,
  input wire sleep_active,
  input wire ramp_to_zero,
  input wire run_led_flash
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ==========================================
  // Loss
  // Below 1000 is a loss and from 3000 a recovery in either mode, so no mode port is needed.
  loss_set_a: assert property (in2_raw_level < 16'h03E8 |=> loss_active)
    else $error("loss not raised");
  loss_clear_a: assert property (in2_raw_level >= 16'h0BB8 |=> !loss_active)
    else $error("loss not cleared");
  loss_hold_a: assert property (loss_active && in2_raw_level < 16'h05DC |=> loss_active)
    else $error("loss dropped early");
  stop_only_a: assert property (stop_req |-> loss_active && !ref_override)
    else $error("stop without loss");
  fault_cause_a: assert property (input_loss_fault |-> loss_active)
    else $error("fault without loss");
  ref_idle_a: assert property (!loss_active |-> ref_value == 16'h0000 && !ref_override)
    else $error("substitute without loss");
  // ==========================================
  // Sleep
  ramp_match_a: assert property (ramp_to_zero == sleep_active)
    else $error("ramp differs from sleep");
  flash_sleep_a: assert property (run_led_flash |-> sleep_active)
    else $error("flash while awake");
  run_gate_a: assert property (!drive_running |=> !sleep_active)
    else $error("sleep while stopped");
endmodule // alsw_checker

bind alsw_ctrl alsw_checker #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
  .clk(clk), .rst_b(rst_b), .in2_raw_level(in2_raw_level), .drive_running(drive_running),
  .loss_active(loss_active), .input_loss_fault(input_loss_fault), .stop_req(stop_req),
  .ref_override(ref_override), .ref_value(ref_value), .sleep_active(sleep_active),
  .ramp_to_zero(ramp_to_zero), .run_led_flash(run_led_flash));

//--- bench/alsw_plant.sv
// Process source and run control facing the block.
// Assumes the bench steps it through put only.
module alsw_plant (
  // Clock
  input wire clk,
  // Process levels
  output reg [15:0] in2_raw_level,
  output reg [15:0] in1_pct,
  // Drive state
  output reg drive_running
);
  timeunit 1ns;
  timeprecision 1ps;
  // A healthy 0-10 V source idles well above the 2 V low point.
  initial begin
    in2_raw_level = 16'h0FA0;
    in1_pct = 16'h01F4;
    drive_running = 1'b0;
    // No analog output is modelled, so its range switch cannot disagree with its mode.
    in1_pct = in1_pct;
  end
  // Steps land just after an edge so the block never sees a half-made change.
  task put(input [15:0] l, input [15:0] p, input r);
    @(posedge clk);
    in2_raw_level <= l;
    in1_pct <= p;
    drive_running <= r;
  endtask
endmodule // alsw_plant

//--- bench/tb_top.sv
// Self-checking bench for the input-2 loss and sleep/wake block.
// Assumes alsw_plant as source and a 10-cycle tick.
`include "alsw_consts.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_b, reg_wr, reg_rd, pid_fb, pid_ref, f;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata, in2_pct, cmd_pct, in2_cmd;
  wire [15:0] reg_rdata, in2_raw_level, in1_pct, ref_value;
  wire drive_running, loss_active, input_loss_fault, stop_req, ref_override;
  wire sleep_active, ramp_to_zero, run_led_flash;
  int mismatches;
  int total_checks;
  int n;
  alsw_plant u_src (.clk(clk), .in2_raw_level(in2_raw_level), .in1_pct(in1_pct), .drive_running(drive_running));
  alsw_ctrl #(.TICK_CYCLES(10)) u_dut (
    .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .in2_raw_level(in2_raw_level), .in1_pct(in1_pct), .in2_pct(in2_pct),
    .cmd_freq_pct(cmd_pct), .drive_running(drive_running), .in2_is_pid_fb(pid_fb), .in2_is_pid_ref(pid_ref),
    .in2_freq_cmd(in2_cmd), .pid_ref_in(16'h0123), .min_freq(16'h0064), .max_freq(16'h03E8),
    .first_preset_frequency(16'h0258), .loss_active(loss_active), .input_loss_fault(input_loss_fault),
    .stop_req(stop_req), .ref_override(ref_override), .ref_value(ref_value), .sleep_active(sleep_active),
    .ramp_to_zero(ramp_to_zero), .run_led_flash(run_led_flash));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ==========================================
  // Helpers
  task chk(input [15:0] got, input [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task wt(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  task wr(input [3:0] a, input [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input [3:0] a, input [15:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // ==========================================
  // Scenarios
  task t_regs;
    rd(`ALSW_REG_LOSS_ACT, 16'h0000);
    rd(`ALSW_REG_SW_SEL, 16'h0000);
    rd(`ALSW_REG_SLP_LVL, 16'h0064);
    rd(`ALSW_REG_SLP_TIME, 16'h0000);
    rd(`ALSW_REG_WAK_LVL, 16'h0096);
    rd(`ALSW_REG_WAK_TIME, 16'h0000);
    rd(4'hF, 16'h0000);
    rd(`ALSW_REG_SLP_SRC, 16'h0000);
    rd(`ALSW_REG_WAK_SRC, 16'h0000);
    rd(`ALSW_REG_PID_SEL, 16'h0000);
    rd(`ALSW_REG_IN2_MODE, 16'h0002);
    wr(`ALSW_REG_SLP_LVL, 16'h0FFF);
    wr(`ALSW_REG_WAK_TIME, 16'hFFFF);
    wr(`ALSW_REG_STATUS, 16'h003F);
    rd(`ALSW_REG_SLP_LVL, 16'h03E8);
    rd(`ALSW_REG_WAK_TIME, 16'h1770);
    rd(`ALSW_REG_STATUS, 16'h0000);
    wr(`ALSW_REG_SLP_LVL, 16'h0064);
    wr(`ALSW_REG_WAK_TIME, 16'h0000);
    $display("test regs done");
  endtask
  task t_loss;
    logic [15:0] ref_exp [8] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0064, 16'h03E8, 16'h0258, 16'h0155};
    for (int c = 0; c < 8; c++) begin
      @(posedge clk);
      in2_cmd <= 16'h0155;
      u_src.put(16'h0FA0, 16'h01F4, 1'b0);
      wr(`ALSW_REG_LOSS_ACT, c[15:0]);
      u_src.put(16'h01F4, 16'h01F4, 1'b0);
      wt(2);
      @(posedge clk);
      in2_cmd <= 16'h0222;
      u_src.put(16'h04B0, 16'h01F4, 1'b0);
      wt(2);
      chk(loss_active, 1'h1);
      chk(input_loss_fault, c == 1);
      chk(stop_req, c == 2);
      chk(ref_override, c >= 3);
      chk(ref_value, ref_exp[c]);
      u_src.put(16'h05DC, 16'h01F4, 1'b0);
      wt(2);
      chk(loss_active, 1'h0);
    end
    $display("test loss done");
  endtask
  task t_pid;
    @(posedge clk);
    pid_fb <= 1'b1;
    pid_ref <= 1'b1;
    wr(`ALSW_REG_PID_SEL, 16'h0001);
    wr(`ALSW_REG_LOSS_ACT, 16'h0007);
    u_src.put(16'h01F4, 16'h01F4, 1'b0);
    wt(2);
    chk(input_loss_fault, 1'h1);
    chk(ref_value, 16'h0123);
    wr(`ALSW_REG_PID_SEL, 16'h0000);
    wt(2);
    chk(input_loss_fault, 1'h0);
    u_src.put(16'h0FA0, 16'h01F4, 1'b0);
    pid_fb <= 1'b0;
    pid_ref <= 1'b0;
    $display("test pid done");
  endtask
  task t_cur;
    wr(`ALSW_REG_IN2_MODE, 16'h0000);
    u_src.put(16'h05DC, 16'h01F4, 1'b0);
    wt(2);
    chk(loss_active, 1'h1);
    u_src.put(16'h09C4, 16'h01F4, 1'b0);
    wt(2);
    chk(loss_active, 1'h1);
    u_src.put(16'h0BB8, 16'h01F4, 1'b0);
    wt(2);
    chk(loss_active, 1'h0);
    wr(`ALSW_REG_IN2_MODE, 16'h0002);
    $display("test current done");
  endtask
  task t_sleep;
    wr(`ALSW_REG_SW_SEL, 16'h0001);
    wr(`ALSW_REG_SLP_TIME, 16'h0005);
    u_src.put(16'h0FA0, 16'h0032, 1'b1);
    wt(35);
    u_src.put(16'h0FA0, 16'h0078, 1'b1);
    u_src.put(16'h0FA0, 16'h0032, 1'b1);
    wt(25);
    chk(sleep_active, 1'h0);
    wt(40);
    chk(sleep_active, 1'h1);
    chk(ramp_to_zero, 1'h1);
    f = run_led_flash;
    n = 0;
    while (run_led_flash === f && n < 60) begin
      wt(1);
      n++;
    end
    chk(n < 60, 1'h1);
    wr(`ALSW_REG_WAK_TIME, 16'h0003);
    u_src.put(16'h0FA0, 16'h00C8, 1'b1);
    wt(5);
    chk(sleep_active, 1'h1);
    wt(40);
    chk(sleep_active, 1'h0);
    chk(run_led_flash, 1'h0);
    wr(`ALSW_REG_WAK_TIME, 16'h0000);
    wr(`ALSW_REG_SLP_TIME, 16'h0000);
    $display("test sleep done");
  endtask
  task t_inv;
    wr(`ALSW_REG_SLP_LVL, 16'h012C);
    wr(`ALSW_REG_WAK_LVL, 16'h00C8);
    u_src.put(16'h0FA0, 16'h0190, 1'b0);
    wt(3);
    chk(sleep_active, 1'h0);
    u_src.put(16'h0FA0, 16'h0190, 1'b1);
    wt(3);
    chk(sleep_active, 1'h1);
    u_src.put(16'h0FA0, 16'h0064, 1'b1);
    wt(3);
    chk(sleep_active, 1'h0);
    wr(`ALSW_REG_SLP_LVL, 16'h0064);
    wr(`ALSW_REG_WAK_LVL, 16'h0096);
    $display("test invert done");
  endtask
  task t_src;
    wr(`ALSW_REG_SLP_SRC, 16'h0002);
    wr(`ALSW_REG_WAK_SRC, 16'h0002);
    for (int s = 0; s < 5; s++) begin
      wr(`ALSW_REG_SW_SEL, s[15:0]);
      @(posedge clk);
      in2_pct <= (s == 2) ? 16'h0032 : 16'h01F4;
      cmd_pct <= (s >= 3) ? 16'h0032 : 16'h01F4;
      u_src.put(16'h0FA0, (s == 1) ? 16'h0032 : 16'h0078, 1'b1);
      wt(3);
      chk(sleep_active, s != 0);
      @(posedge clk);
      in2_pct <= 16'h01F4;
      cmd_pct <= 16'h01F4;
      u_src.put(16'h0FA0, (s == 4) ? 16'h0032 : 16'h01F4, 1'b1);
      wt(3);
      chk(sleep_active, 1'h0);
    end
    $display("test sources done");
  endtask
  task t_rst;
    u_src.put(16'h01F4, 16'h01F4, 1'b0);
    wt(2);
    chk(loss_active, 1'h1);
    rd(`ALSW_REG_STATUS, 16'h0011);
    @(posedge clk);
    rst_b <= 1'b0;
    wt(2);
    chk(loss_active, 1'h0);
    @(posedge clk);
    rst_b <= 1'b1;
    rd(`ALSW_REG_LOSS_ACT, 16'h0000);
    rd(`ALSW_REG_SW_SEL, 16'h0000);
    $display("test reset done");
  endtask
  initial begin
    mismatches = 0;
    total_checks = 0;
    rst_b = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    pid_fb = 1'b0;
    pid_ref = 1'b0;
    in2_pct = 16'h01F4;
    cmd_pct = 16'h01F4;
    in2_cmd = 16'h0155;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    t_regs();
    t_loss();
    t_pid();
    t_cur();
    t_sleep();
    t_inv();
    t_src();
    t_rst();
    give_verdict();
  end
  // The whole run needs about five hundred cycles; ten thousand means a hang.
  initial begin
    #100000;
    mismatches++;
    give_verdict();
  end
endmodule // tb_top

//--- core/alsw_consts.vh
// Constants for the input-2 loss supervisor and sleep/wake controller.
// Assumes a 100 MHz clock and levels already converted by the analog front end.
//
// Contract
// R1: Loss below 1 V or 2 mA.
// R2: Loss clears at 1.5 V or 3 mA.
// R3: Software sets 0-10 V low scale to 20%.
// R4: PID feedback loss faults when both selectors nonzero.
// R5: Codes 0 none, 1 fault, 2 stop.
// R6: Codes 3,4,5 give zero, minimum, maximum.
// R7: Code 6 runs first preset during loss.
// R8: Code 7 holds last command or reference.
// R9: Software stops drive before writing loss action.
// R10: Sleep after signal low for sleep time.
// R11: Sleep ramps to zero and flashes indicator.
// R12: Wake above wake level, ramp back.
// R13: Sleep level above wake level inverts comparisons.
// R14: Source codes 0 off, 1 input1, 2 input2.
// R15: Code 3 commanded frequency, 4 independent selectors.
// R16: Sleep level 0.0-100.0%, 0.1% steps, 10.0%.
// R17: Sleep time 0.0-600.0 s, 0.1 s, zero.
// R18: Wake level same range, default 15.0%.
// R19: Wake after wake time above level.
// R20: Installer matches output range switch to mode.
// R21: Timers count 0.1 s ticks, clear on fail.
// R22: Everything inactive after reset, selectors zero; the input-2 mode select resets to 2.
`ifndef ALSW_CONSTS_VH
`define ALSW_CONSTS_VH
// ==========================================
// Register indices
`define ALSW_REG_LOSS_ACT 4'h0
`define ALSW_REG_SW_SEL 4'h1
`define ALSW_REG_SLP_LVL 4'h2
`define ALSW_REG_SLP_TIME 4'h3
`define ALSW_REG_WAK_LVL 4'h4
`define ALSW_REG_WAK_TIME 4'h5
`define ALSW_REG_SLP_SRC 4'h6
`define ALSW_REG_WAK_SRC 4'h7
`define ALSW_REG_IN2_MODE 4'h8
`define ALSW_REG_PID_SEL 4'h9
`define ALSW_REG_STATUS 4'hA
// ==========================================
// Reset values and limits
`define ALSW_RST_SLP_LVL 16'h0064
`define ALSW_RST_WAK_LVL 16'h0096
`define ALSW_RST_IN2_MODE 16'h0002
`define ALSW_MAX_LVL 16'h03E8
`define ALSW_MAX_TIME 16'h1770
`define ALSW_MAX_LOSS 16'h0007
`define ALSW_MAX_SW 16'h0004
`define ALSW_MAX_SRC 16'h0002
// ==========================================
// Loss thresholds, millivolts or microamps
`define ALSW_LOSS_MV 16'h03E8
`define ALSW_RECOV_MV 16'h05DC
`define ALSW_LOSS_UA 16'h07D0
`define ALSW_RECOV_UA 16'h0BB8
// ==========================================
// Timing
`define ALSW_TICK_MS 100
`define ALSW_CLK_KHZ 100000
`define ALSW_TICK_CYCLES (`ALSW_TICK_MS * `ALSW_CLK_KHZ)
`define ALSW_FLASH_TICKS 16'h0005
`endif

//--- core/alsw_ctrl.v
// Input-2 loss supervisor and sleep/wake controller.
// Assumes synchronous inputs, a plain register port, and a ramp stage downstream.
`include "alsw_consts.vh"

module alsw_ctrl #(
  parameter TICK_CYCLES = `ALSW_TICK_CYCLES
) (
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // Register port
  input wire [3:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata,
  // Measured signals
  input wire [15:0] in2_raw_level,
  input wire [15:0] in1_pct,
  input wire [15:0] in2_pct,
  input wire [15:0] cmd_freq_pct,
  // Drive context
  input wire drive_running,
  input wire in2_is_pid_fb,
  input wire in2_is_pid_ref,
  input wire [15:0] in2_freq_cmd,
  input wire [15:0] pid_ref_in,
  input wire [15:0] min_freq,
  input wire [15:0] max_freq,
  input wire [15:0] first_preset_frequency,
  // Loss responses
  output reg loss_active,
  output reg input_loss_fault,
  output reg stop_req,
  output reg ref_override,
  output reg [15:0] ref_value,
  // Sleep responses
  output reg sleep_active,
  output reg ramp_to_zero,
  output reg run_led_flash
);

  // ==========================================
  // Helpers

  function [15:0] clamp;
    input [15:0] v;
    input [15:0] lim;
    begin
      clamp = (v > lim) ? lim : v;
    end
  endfunction

  function [15:0] pick_src;
    input [15:0] code;
    input [15:0] a1;
    input [15:0] a2;
    input [15:0] cf;
    begin
      case (code)
        16'h0000: pick_src = a1;
        16'h0001: pick_src = a2;
        default: pick_src = cf;
      endcase
    end
  endfunction

  // The held source is passed in so that the combinational callers stay sensitive to it.
  function [15:0] hold_pick;
    input is_ref;
    input [15:0] pr;
    input [15:0] fc;
    begin
      hold_pick = is_ref ? pr : fc;
    end
  endfunction

  // ==========================================
  // Parameter store

  reg [15:0] input2_loss_action_r;
  reg [15:0] sleep_wake_source_select_r;
  reg [15:0] sleep_threshold_level_r;
  reg [15:0] sleep_qualify_time_r;
  reg [15:0] wake_threshold_level_r;
  reg [15:0] wake_qualify_time_r;
  reg [15:0] sleep_source_select_r;
  reg [15:0] wake_source_select_r;
  reg [15:0] input2_mode_select_r;
  reg [15:0] pid_reference_select_r;

  // Out-of-range writes are clamped, except to the PID select, so the logic never sees an undefined code.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      input2_loss_action_r <= 16'h0000; // R22
      sleep_wake_source_select_r <= 16'h0000; // R22
      sleep_threshold_level_r <= `ALSW_RST_SLP_LVL; // R16
      sleep_qualify_time_r <= 16'h0000; // R17
      wake_threshold_level_r <= `ALSW_RST_WAK_LVL; // R18
      wake_qualify_time_r <= 16'h0000; // R19
      sleep_source_select_r <= 16'h0000;
      wake_source_select_r <= 16'h0000;
      input2_mode_select_r <= `ALSW_RST_IN2_MODE;
      pid_reference_select_r <= 16'h0000;
    end else if (reg_wr) begin
      case (reg_addr)
        `ALSW_REG_LOSS_ACT: input2_loss_action_r <= clamp(reg_wdata, `ALSW_MAX_LOSS);
        `ALSW_REG_SW_SEL: sleep_wake_source_select_r <= clamp(reg_wdata, `ALSW_MAX_SW);
        `ALSW_REG_SLP_LVL: sleep_threshold_level_r <= clamp(reg_wdata, `ALSW_MAX_LVL); // R16
        `ALSW_REG_SLP_TIME: sleep_qualify_time_r <= clamp(reg_wdata, `ALSW_MAX_TIME); // R17
        `ALSW_REG_WAK_LVL: wake_threshold_level_r <= clamp(reg_wdata, `ALSW_MAX_LVL); // R18
        `ALSW_REG_WAK_TIME: wake_qualify_time_r <= clamp(reg_wdata, `ALSW_MAX_TIME); // R19
        `ALSW_REG_SLP_SRC: sleep_source_select_r <= clamp(reg_wdata, `ALSW_MAX_SRC);
        `ALSW_REG_WAK_SRC: wake_source_select_r <= clamp(reg_wdata, `ALSW_MAX_SRC);
        `ALSW_REG_IN2_MODE: input2_mode_select_r <= clamp(reg_wdata, `ALSW_MAX_LOSS);
        `ALSW_REG_PID_SEL: pid_reference_select_r <= reg_wdata;
        default: begin
        end
      endcase
    end
  end

  // ==========================================
  // Read port

  reg [15:0] rdata_nxt;

  always @* begin
    case (reg_addr)
      `ALSW_REG_LOSS_ACT: rdata_nxt = input2_loss_action_r;
      `ALSW_REG_SW_SEL: rdata_nxt = sleep_wake_source_select_r;
      `ALSW_REG_SLP_LVL: rdata_nxt = sleep_threshold_level_r;
      `ALSW_REG_SLP_TIME: rdata_nxt = sleep_qualify_time_r;
      `ALSW_REG_WAK_LVL: rdata_nxt = wake_threshold_level_r;
      `ALSW_REG_WAK_TIME: rdata_nxt = wake_qualify_time_r;
      `ALSW_REG_SLP_SRC: rdata_nxt = sleep_source_select_r;
      `ALSW_REG_WAK_SRC: rdata_nxt = wake_source_select_r;
      `ALSW_REG_IN2_MODE: rdata_nxt = input2_mode_select_r;
      `ALSW_REG_PID_SEL: rdata_nxt = pid_reference_select_r;
      `ALSW_REG_STATUS: rdata_nxt = {10'h000, run_led_flash, ref_override, stop_req,
                                     input_loss_fault, sleep_active, loss_active};
      default: rdata_nxt = 16'h0000;
    endcase
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      reg_rdata <= rdata_nxt;
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // ==========================================
  // Tenth-second tick

  reg [31:0] tick_cnt_r;
  reg tick_r;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tick_cnt_r <= 32'h00000000;
      tick_r <= 1'b0;
    end else if (tick_cnt_r >= TICK_CYCLES - 1) begin
      tick_cnt_r <= 32'h00000000; // R21
      tick_r <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h00000001;
      tick_r <= 1'b0;
    end
  end

  // ==========================================
  // Loss detection with hysteresis

  // Current modes have bit 1 clear; the voltage modes all have it set.
  wire volt_mode = input2_mode_select_r[1];
  wire [15:0] loss_thr = volt_mode ? `ALSW_LOSS_MV : `ALSW_LOSS_UA;
  wire [15:0] recov_thr = volt_mode ? `ALSW_RECOV_MV : `ALSW_RECOV_UA;
  reg loss_nxt;

  always @* begin
    loss_nxt = loss_active;
    if (!loss_active && in2_raw_level < loss_thr) begin
      loss_nxt = 1'b1; // R1
    end else if (loss_active && in2_raw_level >= recov_thr) begin
      loss_nxt = 1'b0; // R2
    end
  end

  // ==========================================
  // Loss response

  reg [15:0] hold_val_r;
  wire [15:0] act = input2_loss_action_r;
  wire pid_fault = in2_is_pid_fb && act != 16'h0000 && pid_reference_select_r != 16'h0000;
  reg [15:0] ref_nxt;

  // The held value is frozen from the first cycle of loss onward.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hold_val_r <= 16'h0000;
    end else if (!loss_active) begin
      hold_val_r <= hold_pick(in2_is_pid_ref, pid_ref_in, in2_freq_cmd); // R8
    end
  end

  always @* begin
    case (act)
      16'h0003: ref_nxt = 16'h0000; // R6
      16'h0004: ref_nxt = min_freq; // R6
      16'h0005: ref_nxt = max_freq; // R6
      16'h0006: ref_nxt = first_preset_frequency; // R7
      16'h0007: ref_nxt = loss_active ? hold_val_r : hold_pick(in2_is_pid_ref, pid_ref_in, in2_freq_cmd); // R8
      default: ref_nxt = 16'h0000;
    endcase
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      loss_active <= 1'b0; // R22
      input_loss_fault <= 1'b0;
      stop_req <= 1'b0;
      ref_override <= 1'b0;
      ref_value <= 16'h0000;
    end else begin
      loss_active <= loss_nxt;
      input_loss_fault <= loss_nxt && (act == 16'h0001 || pid_fault); // R4 R5
      stop_req <= loss_nxt && act == 16'h0002; // R5
      ref_override <= loss_nxt && act >= 16'h0003; // R6 R7 R8
      ref_value <= loss_nxt ? ref_nxt : 16'h0000;
    end
  end

  // ==========================================
  // Sleep/wake source and comparisons

  wire [15:0] sw = sleep_wake_source_select_r;
  wire sw_on = sw != 16'h0000; // R14
  reg [15:0] slp_sig;
  reg [15:0] wak_sig;

  always @* begin
    case (sw)
      16'h0001: begin
        slp_sig = in1_pct; // R14
        wak_sig = in1_pct;
      end
      16'h0002: begin
        slp_sig = in2_pct; // R14
        wak_sig = in2_pct;
      end
      16'h0003: begin
        slp_sig = cmd_freq_pct; // R15
        wak_sig = cmd_freq_pct;
      end
      16'h0004: begin
        slp_sig = pick_src(sleep_source_select_r, in1_pct, in2_pct, cmd_freq_pct); // R15
        wak_sig = pick_src(wake_source_select_r, in1_pct, in2_pct, cmd_freq_pct);
      end
      default: begin
        slp_sig = 16'h0000;
        wak_sig = 16'h0000;
      end
    endcase
  end

  wire inv = sleep_threshold_level_r > wake_threshold_level_r; // R13
  wire slp_cond = inv ? (slp_sig > sleep_threshold_level_r) : (slp_sig < sleep_threshold_level_r); // R10 R13
  wire wak_cond = inv ? (wak_sig < wake_threshold_level_r) : (wak_sig > wake_threshold_level_r); // R12 R13

  // ==========================================
  // Qualification timers

  reg [15:0] slp_cnt_r;
  reg [15:0] wak_cnt_r;

  // Counts saturate so a long dwell cannot wrap and re-arm the wait.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      slp_cnt_r <= 16'h0000;
      wak_cnt_r <= 16'h0000;
    end else begin
      if (!slp_cond || sleep_active || !drive_running) begin
        slp_cnt_r <= 16'h0000; // R21
      end else if (tick_r && slp_cnt_r != 16'hFFFF) begin
        slp_cnt_r <= slp_cnt_r + 16'h0001; // R21
      end
      if (!wak_cond || !sleep_active) begin
        wak_cnt_r <= 16'h0000; // R21
      end else if (tick_r && wak_cnt_r != 16'hFFFF) begin
        wak_cnt_r <= wak_cnt_r + 16'h0001; // R21
      end
    end
  end

  wire slp_go = sw_on && drive_running && slp_cond && slp_cnt_r >= sleep_qualify_time_r; // R10 R17
  wire wak_go = wak_cond && wak_cnt_r >= wake_qualify_time_r; // R19

  // ==========================================
  // Sleep state and indicator

  reg [15:0] flash_cnt_r;
  reg sleep_nxt;

  always @* begin
    sleep_nxt = sleep_active;
    if (!sw_on || !drive_running) begin
      sleep_nxt = 1'b0;
    end else if (!sleep_active && slp_go) begin
      sleep_nxt = 1'b1; // R10
    end else if (sleep_active && wak_go) begin
      sleep_nxt = 1'b0; // R12
    end
  end

  // The indicator follows the next sleep state so it never outlives sleep by a cycle.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sleep_active <= 1'b0; // R22
      ramp_to_zero <= 1'b0;
      run_led_flash <= 1'b0;
      flash_cnt_r <= 16'h0000;
    end else begin
      sleep_active <= sleep_nxt; // R10 R12
      ramp_to_zero <= sleep_nxt; // R11
      if (!sleep_nxt) begin
        flash_cnt_r <= 16'h0000;
        run_led_flash <= 1'b0;
      end else if (tick_r) begin
        if (flash_cnt_r >= `ALSW_FLASH_TICKS - 16'h0001) begin
          flash_cnt_r <= 16'h0000;
          run_led_flash <= ~run_led_flash; // R11
        end else begin
          flash_cnt_r <= flash_cnt_r + 16'h0001;
        end
      end
    end
  end

endmodule // alsw_ctrl
